// ==== psbs_pkg.sv ====
/*
  Shared constants and types of the parameter save bank sequencer:
  register map, command codes, default values, memory request and
  answer layouts, sequencer states and timing.
  Assumes a 100 MHz system clock and a 32-bit classic bus slave.
*/
package psbs_pkg;

  // ==========================================================
  // Register map and fields
  localparam logic [7:0]  ADDR_CMD       = 8'h00;
  localparam logic [7:0]  ADDR_CTRL      = 8'h04;
  localparam logic [7:0]  ADDR_STAT      = 8'h08;
  localparam int          CTRL_RESET     = 0;
  localparam int          CTRL_QUICK     = 1;
  localparam int          CTRL_CARD      = 2;
  localparam int          CTRL_CLRTRIP   = 3;
  localparam int          CTRL_ENABLE    = 4;
  localparam logic [15:0] CMD_RESET_VAL  = 16'h0000;

  // ==========================================================
  // Command codes
  localparam logic [15:0] CODE_SAVE_MAINS = 16'h03E8;
  localparam logic [15:0] CODE_SAVE_ANY   = 16'h03E9;
  localparam logic [15:0] CODE_DEF_STD    = 16'h04D1;
  localparam logic [15:0] CODE_DEF_REG    = 16'h04DC;
  localparam logic [15:0] CODE_MODE_STD   = 16'h04E5;
  localparam logic [15:0] CODE_MODE_REG   = 16'h04E6;
  localparam logic [15:0] CODE_MODE_XSTD  = 16'h04E7;
  localparam logic [15:0] CODE_MODE_XREG  = 16'h04E8;
  localparam logic [15:0] CODE_NAME_BASE  = 16'h2AF8;
  localparam logic [15:0] CODE_NAME_LAST  = 16'h2B1F;
  localparam logic [15:0] NAME_SLOT1_OFS  = 16'h000A;
  localparam logic [15:0] NAME_SLOT2_OFS  = 16'h0014;
  localparam logic [15:0] NAME_SLOT3_OFS  = 16'h001E;
  localparam logic [15:0] CODE_DISP_NDEF  = 16'h2EE0;
  localparam logic [15:0] CODE_DISP_DESTINATION_CLASH_TRIP  = 16'h2EE1;

  // ==========================================================
  // Default value sets (regional set; standard set plain values)
  localparam logic [15:0] REG_CLAMP_DHZ   = 16'h0258;
  localparam logic [15:0] REG_CLAMP_RPM   = 16'h0708;
  localparam logic [15:0] REG_RATED_V     = 16'h01CC;
  localparam logic [15:0] STD_CLAMP_DHZ   = 16'h01F4;
  localparam logic [15:0] STD_CLAMP_RPM   = 16'h05DC;
  localparam logic [15:0] STD_RATED_V     = 16'h0190;

  // ==========================================================
  // Timing and bank reinitialisation
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          SAVE_MIN_MS     = 400;
  localparam int          SAVE_MIN_CYC    = SAVE_MIN_MS * (CLK_HZ / 1000);
  localparam logic [1:0]  REINIT_SAVES    = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    DISP_ALL  = 2'b00,
    DISP_NDEF = 2'b01,
    DISP_DESTINATION_CLASH_TRIP = 2'b10
  } psbs_disp_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_SCAN = 4'b0001, OP_ERASE_ALL = 4'b0010,
    OP_LOAD_DEF = 4'b0011, OP_NAMEPLATE = 4'b0100, OP_ERASE_BANK = 4'b0101,
    OP_WRITE = 4'b0110, OP_COMMIT = 4'b0111, OP_CARD_WR = 4'b1000
  } psbs_op_t;

  typedef enum logic [3:0] {
    ST_SCAN = 4'b0000, ST_IDLE = 4'b0001, ST_ERASE_ALL = 4'b0010,
    ST_LOAD_DEF = 4'b0011, ST_NAMEPLATE = 4'b0100, ST_ERASE_BANK = 4'b0101,
    ST_WRITE = 4'b0110, ST_COMMIT = 4'b0111, ST_HOLD = 4'b1000,
    ST_DIRECT = 4'b1001, ST_DONE = 4'b1010
  } psbs_state_t;

  // Step order of a job, one pending bit each
  localparam int P_ERASE_ALL = 0;
  localparam int P_LOAD_DEF  = 1;
  localparam int P_NAMEPLATE = 2;
  localparam int P_ERASE_BNK = 3;
  localparam int P_WRITE     = 4;
  localparam int P_COMMIT    = 5;
  localparam int P_DIRECT    = 6;
  localparam int P_STEPS     = 7;

  typedef struct packed {
    logic        valid;
    psbs_op_t    op;
    logic        bank;
    logic        inclPds;
    logic        regional;
    logic        exclMenus;
    logic [1:0]  slot;
    logic [3:0]  digit;
    logic [15:0] clamp;
    logic [15:0] ratedV;
  } psbs_mem_req_t;

  typedef struct packed {
    logic       ack;
    logic       err;
    logic [1:0] bankValid;
    logic       userTorn;
    logic       pdsTorn;
    logic       lastActive;
  } psbs_mem_rsp_t;

endpackage

// ==== psbs_sequencer.sv ====
/*
  Parameter save bank sequencer: command register, classic bus slave,
  and the sequencer that drives the two-bank non-volatile memory.
  Assumes the memory answers on sys_clk with a one-cycle ack per
  request, and that supply flags and straps arrive asynchronously.
*/
`timescale 1ns/10ps

// What this block does
// RULE1: Save codes plus drive reset start save
// RULE2: Power-down data saved only on commanded saves
// RULE3: Successful command clears command parameter
// RULE4: Save lasts at least 400 ms
// RULE5: Code 1000 saves only on mains supply
// RULE6: Operator uses 1001 off mains
// RULE7: Write inactive bank, switch when complete
// RULE8: Torn save raises trip, reverts bank
// RULE9: No valid bank raises corruption trip
// RULE10: Quick edits write active bank directly
// RULE11: Auto save after nameplate, card, defaults; card writes here end in ST_DONE without a save
// RULE12: Card writes have no bank protection
// RULE13: Mode change erases, defaults, saves power-down
// RULE14: First save after mode change longer
// RULE15: Option change reinitialises both banks
// RULE16: Codes 1233/1244 load standard/regional defaults
// RULE17: Regional set changes clamp and voltage
// RULE18: Code 110zy transfers nameplate per slot
// RULE19: Codes 12000/12001 filter the display
// RULE20: Started then failed: trip, keep code
// RULE21: Not started: no clear, no trip
// RULE22: Codes 1253-1256 change drive mode
// RULE23: Busy flag shown during operations
module psbs_sequencer
  import psbs_pkg::*;
#(
  parameter int SAVE_CYC = SAVE_MIN_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_cyc_i,
  output logic               wb_ack_o,
  input  wire logic          undervoltageActiveFlag,
  input  wire logic          lowVoltageSupplyFlag,
  input  wire logic          closedLoopMode,
  input  wire logic          unit400V,
  input  wire logic          optionChangeToggle,
  output psbs_mem_req_t      memReq_r,
  input  wire psbs_mem_rsp_t memRsp,
  output logic               busy_r,
  output logic               userSaveErrorTrip_r,
  output logic               powerdownSaveErrorTrip_r,
  output logic               memoryCorruptTrip_r,
  output logic               actionFailTrip_r,
  output psbs_disp_t         displayMode_r
);

  // ==========================================================
  // Synchronisers for asynchronous inputs
  logic [4:0]    syncA_r;
  logic [4:0]    syncB_r;
  logic          optPrev_r;
  logic          uvSync;
  logic          lvSync;
  logic          clSync;
  logic          u400Sync;
  logic          optionEvent;

  // Two flops per pin, third flop for the option edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_r   <= 5'h00;
      syncB_r   <= 5'h00;
      optPrev_r <= 1'b0;
    end else begin
      syncA_r   <= {optionChangeToggle, unit400V, closedLoopMode,
                    lowVoltageSupplyFlag, undervoltageActiveFlag};
      syncB_r   <= syncA_r;
      optPrev_r <= syncB_r[4];
    end
  end

  assign uvSync      = syncB_r[0];
  assign lvSync      = syncB_r[1];
  assign clSync      = syncB_r[2];
  assign u400Sync    = syncB_r[3];
  assign optionEvent = syncB_r[4] ^ optPrev_r;

  // ==========================================================
  // Bus slave decode
  logic          wbReq;
  logic          wrCmd;
  logic          wrCtrl;
  psbs_state_t   state_r;
  logic [15:0]   cmd_r;
  logic          driveEnabled_r;
  logic          doneClear;
  logic          idle;

  assign wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idle   = (state_r == ST_IDLE);
  assign wrCmd  = wbReq & wb_we_i & (wb_adr_i == ADDR_CMD);
  assign wrCtrl = wbReq & wb_we_i & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0];

  // Ack one cycle after the request, unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        if (wb_adr_i == ADDR_CMD) begin
          wb_dat_o <= {16'h0000, cmd_r};
        end else if (wb_adr_i == ADDR_CTRL) begin
          wb_dat_o <= {27'h0000000, driveEnabled_r, 4'h0};
        end else if (wb_adr_i == ADDR_STAT) begin
          wb_dat_o <= {24'h000000, displayMode_r, actionFailTrip_r,
                       memoryCorruptTrip_r, powerdownSaveErrorTrip_r,
                       userSaveErrorTrip_r, memReq_r.bank, busy_r};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================
  // Command parameter and control bits
  logic          resetPulse;
  logic          quickPulse;
  logic          cardPulse;
  logic          clearTrips;

  // RULE3: clear after success
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_r <= CMD_RESET_VAL;
    end else if (doneClear) begin
      cmd_r <= CMD_RESET_VAL;
    end else if (wrCmd && idle) begin
      if (wb_sel_i[0]) cmd_r[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) cmd_r[15:8] <= wb_dat_i[15:8];
    end
  end

  // Enable level and one-cycle control strobes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      driveEnabled_r <= 1'b0;
    end else if (wrCtrl) begin
      driveEnabled_r <= wb_dat_i[CTRL_ENABLE];
    end
  end

  // RULE23: reset, quick and card strobes taken only when idle
  assign resetPulse = wrCtrl & idle & wb_dat_i[CTRL_RESET];
  assign quickPulse = wrCtrl & idle & wb_dat_i[CTRL_QUICK] & ~wb_dat_i[CTRL_RESET];
  assign cardPulse  = wrCtrl & idle & wb_dat_i[CTRL_CARD] & ~wb_dat_i[CTRL_RESET]
                      & ~wb_dat_i[CTRL_QUICK];
  assign clearTrips = wrCtrl & wb_dat_i[CTRL_CLRTRIP];

  // RULE19: display filter takes effect on write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      displayMode_r <= DISP_ALL;
    end else if (wrCmd && idle && wb_sel_i[1] && wb_sel_i[0]) begin
      if (wb_dat_i[15:0] == CODE_DISP_NDEF) begin
        displayMode_r <= DISP_NDEF;
      end else if (wb_dat_i[15:0] == CODE_DISP_DESTINATION_CLASH_TRIP) begin
        displayMode_r <= DISP_DESTINATION_CLASH_TRIP;
      end
    end
  end

  // ==========================================================
  // Command decode on drive reset
  logic [P_STEPS-1:0] startPend;
  logic               startPds;
  logic               startReg;
  logic               startExcl;
  logic               startMode;
  logic [1:0]         startSlot;
  logic [15:0]        nameOff;
  logic [15:0]        digitOff;
  logic [1:0]         reinit_r;
  logic               blocked;

  always_comb begin
    startPend = '0;
    startPds  = 1'b0;
    startReg  = 1'b0;
    startExcl = 1'b0;
    startMode = 1'b0;
    startSlot = 2'h0;
    nameOff   = cmd_r - CODE_NAME_BASE;
    digitOff  = nameOff;
    blocked   = memoryCorruptTrip_r;
    // RULE1: either save code
    if ((cmd_r == CODE_SAVE_MAINS) || (cmd_r == CODE_SAVE_ANY)) begin
      // RULE5: mains check for code 1000
      if (!blocked && ((cmd_r == CODE_SAVE_ANY) || (!uvSync && !lvSync))) begin
        startPend[P_WRITE]  = 1'b1;
        startPend[P_COMMIT] = 1'b1;
        // RULE2: commanded save adds power-down data
        startPds            = 1'b1;
      end
    end else if ((cmd_r == CODE_DEF_STD) || (cmd_r == CODE_DEF_REG)) begin
      // RULE16: defaults, RULE21: refused while enabled
      if (!driveEnabled_r) begin
        startPend[P_LOAD_DEF] = 1'b1;
        // RULE11: save after defaults
        startPend[P_WRITE]    = 1'b1;
        startPend[P_COMMIT]   = 1'b1;
        startReg              = (cmd_r == CODE_DEF_REG);
      end
    end else if ((cmd_r >= CODE_MODE_STD) && (cmd_r <= CODE_MODE_XREG)) begin
      // RULE22: mode change variants
      if (!driveEnabled_r && !blocked) begin
        // RULE13: erase, defaults, save with power-down
        startPend[P_ERASE_ALL] = 1'b1;
        startPend[P_LOAD_DEF]  = 1'b1;
        startPend[P_WRITE]     = 1'b1;
        startPend[P_COMMIT]    = 1'b1;
        startPds               = 1'b1;
        startMode              = 1'b1;
        startReg  = (cmd_r == CODE_MODE_REG) || (cmd_r == CODE_MODE_XREG);
        startExcl = (cmd_r == CODE_MODE_XSTD) || (cmd_r == CODE_MODE_XREG);
      end
    end else if ((cmd_r >= CODE_NAME_BASE) && (cmd_r <= CODE_NAME_LAST)) begin
      // RULE18: slot from tens digit, low digit passed on
      if (!driveEnabled_r && !blocked) begin
        startPend[P_NAMEPLATE] = 1'b1;
        // RULE11: save after nameplate transfer
        startPend[P_WRITE]     = 1'b1;
        startPend[P_COMMIT]    = 1'b1;
        if (nameOff >= NAME_SLOT3_OFS) begin
          startSlot = 2'h3;
          digitOff  = nameOff - NAME_SLOT3_OFS;
        end else if (nameOff >= NAME_SLOT2_OFS) begin
          startSlot = 2'h2;
          digitOff  = nameOff - NAME_SLOT2_OFS;
        end else if (nameOff >= NAME_SLOT1_OFS) begin
          startSlot = 2'h1;
          digitOff  = nameOff - NAME_SLOT1_OFS;
        end
      end
    end
    // RULE15: bank cleared before write while reinitialising
    if (startPend[P_WRITE] && (reinit_r != 2'h0) && !startMode) begin
      startPend[P_ERASE_BNK] = 1'b1;
    end
  end

  // ==========================================================
  // Step selection and memory request build
  logic [P_STEPS-1:0] pend_r;
  logic [P_STEPS-1:0] pendLeft;
  logic [P_STEPS-1:0] curBit;
  psbs_state_t        nextStep;
  psbs_mem_req_t      reqOf;
  logic               activeBank_r;
  logic               jobPds_r;
  logic               jobReg_r;
  logic               jobExcl_r;
  logic               jobMode_r;
  logic               jobCmd_r;
  logic               jobCard_r;
  logic [1:0]         jobSlot_r;
  logic [3:0]         jobDigit_r;
  logic [31:0]        holdCnt_r;

  always_comb begin
    curBit = '0;
    case (state_r)
      ST_ERASE_ALL:  curBit[P_ERASE_ALL] = 1'b1;
      ST_LOAD_DEF:   curBit[P_LOAD_DEF]  = 1'b1;
      ST_NAMEPLATE:  curBit[P_NAMEPLATE] = 1'b1;
      ST_ERASE_BANK: curBit[P_ERASE_BNK] = 1'b1;
      ST_WRITE:      curBit[P_WRITE]     = 1'b1;
      ST_COMMIT:     curBit[P_COMMIT]    = 1'b1;
      ST_DIRECT:     curBit[P_DIRECT]    = 1'b1;
      default:       curBit              = '0;
    endcase
    pendLeft = pend_r & ~curBit;
    if (pendLeft[P_ERASE_ALL])      nextStep = ST_ERASE_ALL;
    else if (pendLeft[P_LOAD_DEF])  nextStep = ST_LOAD_DEF;
    else if (pendLeft[P_NAMEPLATE]) nextStep = ST_NAMEPLATE;
    else if (pendLeft[P_ERASE_BNK]) nextStep = ST_ERASE_BANK;
    else if (pendLeft[P_WRITE])     nextStep = ST_WRITE;
    else if (pendLeft[P_COMMIT])    nextStep = ST_COMMIT;
    else if (pendLeft[P_DIRECT])    nextStep = ST_DIRECT;
    else if (pend_r[P_COMMIT])      nextStep = ST_HOLD;
    else                            nextStep = ST_DONE;
  end

  always_comb begin
    reqOf           = '0;
    reqOf.valid     = 1'b1;
    // RULE7: new data goes to the inactive bank
    reqOf.bank      = ~activeBank_r;
    reqOf.inclPds   = jobPds_r;
    reqOf.regional  = jobReg_r;
    reqOf.exclMenus = jobExcl_r;
    reqOf.slot      = jobSlot_r;
    reqOf.digit     = jobDigit_r;
    // RULE17: regional clamp and voltage values
    if (clSync) reqOf.clamp = jobReg_r ? REG_CLAMP_RPM : STD_CLAMP_RPM;
    else        reqOf.clamp = jobReg_r ? REG_CLAMP_DHZ : STD_CLAMP_DHZ;
    reqOf.ratedV = (jobReg_r && u400Sync) ? REG_RATED_V : STD_RATED_V;
    case (state_r)
      ST_SCAN:       reqOf.op = OP_SCAN;
      ST_ERASE_ALL:  reqOf.op = OP_ERASE_ALL;
      ST_LOAD_DEF:   reqOf.op = OP_LOAD_DEF;
      ST_NAMEPLATE:  reqOf.op = OP_NAMEPLATE;
      ST_ERASE_BANK: reqOf.op = OP_ERASE_BANK;
      ST_WRITE:      reqOf.op = OP_WRITE;
      ST_COMMIT:     reqOf.op = OP_COMMIT;
      ST_DIRECT: begin
        // RULE10: quick edits go to the active bank
        reqOf.bank    = activeBank_r;
        reqOf.inclPds = 1'b0;
        // RULE12: card writes bypass the bank scheme
        reqOf.op      = jobCard_r ? OP_CARD_WR : OP_WRITE;
      end
      default:       reqOf.op = OP_NONE;
    endcase
  end

  // ==========================================================
  // Sequencer
  logic          opAck;
  logic          opFail;
  logic          holdDone;

  assign opAck     = memReq_r.valid & memRsp.ack;
  assign opFail    = opAck & memRsp.err;
  // RULE4: minimum save duration
  assign holdDone  = (holdCnt_r >= (SAVE_CYC - 1));
  assign doneClear = (state_r == ST_DONE) & jobCmd_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r  <= ST_SCAN;
      pend_r   <= '0;
      memReq_r <= '0;
      busy_r   <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          busy_r <= 1'b0;
          if (resetPulse && (startPend != '0)) begin
            pend_r  <= startPend;
            state_r <= ST_WAIT_SEL(startPend);
            busy_r  <= 1'b1;
          end else if (quickPulse || cardPulse) begin
            pend_r  <= P_STEPS'(1) << P_DIRECT;
            state_r <= ST_DIRECT;
            busy_r  <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (holdDone) state_r <= ST_DONE;
        end
        ST_DONE: begin
          pend_r  <= '0;
          state_r <= ST_IDLE;
        end
        default: begin
          // Every memory step: raise, hold until ack, then move on
          if (opFail) begin
            // RULE20: failed job keeps the code
            memReq_r.valid <= 1'b0;
            pend_r         <= '0;
            state_r        <= ST_IDLE;
          end else if (opAck) begin
            memReq_r.valid <= 1'b0;
            pend_r         <= pendLeft;
            state_r        <= (state_r == ST_SCAN) ? ST_IDLE : nextStep;
          end else if (!memReq_r.valid) begin
            memReq_r <= reqOf;
          end
        end
      endcase
    end
  end

  // First step of a freshly decoded job
  function automatic psbs_state_t ST_WAIT_SEL(input logic [P_STEPS-1:0] p);
    if (p[P_ERASE_ALL])      return ST_ERASE_ALL;
    else if (p[P_LOAD_DEF])  return ST_LOAD_DEF;
    else if (p[P_NAMEPLATE]) return ST_NAMEPLATE;
    else if (p[P_ERASE_BNK]) return ST_ERASE_BANK;
    else                     return ST_WRITE;
  endfunction

  // Job attributes latched when a job is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      jobPds_r   <= 1'b0;
      jobReg_r   <= 1'b0;
      jobExcl_r  <= 1'b0;
      jobMode_r  <= 1'b0;
      jobCmd_r   <= 1'b0;
      jobCard_r  <= 1'b0;
      jobSlot_r  <= 2'h0;
      jobDigit_r <= 4'h0;
    end else if (idle && (resetPulse || quickPulse || cardPulse)) begin
      jobPds_r   <= resetPulse & startPds;
      jobReg_r   <= startReg;
      jobExcl_r  <= startExcl;
      jobMode_r  <= startMode;
      jobCmd_r   <= resetPulse;
      jobCard_r  <= ~resetPulse & cardPulse;
      jobSlot_r  <= startSlot;
      jobDigit_r <= digitOff[3:0];
    end
  end

  // Save time counted from the start of the job
  always_ff @(posedge sys_clk) begin
    if (rst || idle) begin
      holdCnt_r <= 32'h0000_0000;
    end else if (!holdDone) begin
      holdCnt_r <= holdCnt_r + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Active bank and reinitialisation count
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      activeBank_r <= 1'b0;
    end else if (opAck && !memRsp.err && (state_r == ST_SCAN)) begin
      // RULE8: revert to the last good bank
      activeBank_r <= memRsp.lastActive;
    end else if (opAck && !memRsp.err && (state_r == ST_COMMIT)) begin
      // RULE7: switch only after the full write
      activeBank_r <= ~activeBank_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reinit_r <= 2'h0;
    end else if (optionEvent) begin
      // RULE15: both banks rebuilt on next saves
      reinit_r <= REINIT_SAVES;
    end else if (opAck && !memRsp.err && (state_r == ST_COMMIT)) begin
      if (jobMode_r) begin
        // RULE14: extra bank clear on next save
        reinit_r <= (reinit_r == 2'h0) ? 2'h1 : reinit_r;
      end else if (reinit_r != 2'h0) begin
        reinit_r <= reinit_r - 2'h1;
      end
    end
  end

  // ==========================================================
  // Trips: hardware set wins over software clear
  logic          scanOk;
  assign scanOk = opAck & ~memRsp.err & (state_r == ST_SCAN);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      userSaveErrorTrip_r      <= 1'b0;
      powerdownSaveErrorTrip_r <= 1'b0;
      actionFailTrip_r         <= 1'b0;
    end else begin
      // RULE8: torn save trips at power-up
      if (scanOk && memRsp.userTorn) userSaveErrorTrip_r <= 1'b1;
      else if (clearTrips)           userSaveErrorTrip_r <= 1'b0;
      if (scanOk && memRsp.pdsTorn)  powerdownSaveErrorTrip_r <= 1'b1;
      else if (clearTrips)           powerdownSaveErrorTrip_r <= 1'b0;
      // RULE20: failure after start trips
      if (opFail)                    actionFailTrip_r <= 1'b1;
      else if (clearTrips)           actionFailTrip_r <= 1'b0;
    end
  end

  // RULE9: no valid bank at power-up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memoryCorruptTrip_r <= 1'b0;
    end else if ((state_r == ST_SCAN) && opAck
                 && (memRsp.err || (memRsp.bankValid == 2'b00))) begin
      memoryCorruptTrip_r <= 1'b1;
    end else if ((state_r == ST_LOAD_DEF) && opAck && !memRsp.err) begin
      memoryCorruptTrip_r <= 1'b0;
    end
  end

endmodule

// ==== psbs_checker_assertions.sv ====
/* Checks sequencer ports. Assumes bind into each sequencer. */
`timescale 1ns/10ps
module psbs_checker
  import psbs_pkg::*;
#(parameter int SAVE_CYC = SAVE_MIN_CYC) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire psbs_mem_req_t memReq_r,
  input wire psbs_mem_rsp_t memRsp,
  input wire logic busy_r,
  input wire logic userSaveErrorTrip_r,
  input wire logic memoryCorruptTrip_r,
  input wire logic actionFailTrip_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic cmt_r;
  logic [31:0] cnt_r;
  wire ack = memReq_r.valid && memRsp.ack;
  wire scan = ack && memReq_r.op == OP_SCAN;
  wire err = ack && memRsp.err && !scan;
  // Busy spell length, good commit seen
  always_ff @(posedge sys_clk) begin
    cnt_r <= (busy_r && !rst) ? cnt_r + 32'h1 : 32'h0;
    cmt_r <= busy_r && !rst && (cmt_r || ack && !memRsp.err && memReq_r.op == OP_COMMIT);
  end
  sequence s_job_end;
    $fell(busy_r) && cmt_r;
  endsequence
  chk_req_drop: assert property (ack |=> !memReq_r.valid)
    else $error("request held");
  chk_scan_first: assert property ($fell(rst) |=> memReq_r.op == OP_SCAN)
    else $error("no scan");
  chk_req_hold: assert property (memReq_r.valid && !memRsp.ack |=> $stable(memReq_r))
    else $error("request moved");
  chk_req_busy: assert property (memReq_r.valid |-> busy_r)
    else $error("not busy");
  chk_save_len: assert property (s_job_end |-> cnt_r >= SAVE_CYC - 1)
    else $error("save short");
  chk_torn_trip: assert property (scan && memRsp.userTorn |-> ##[1:3] userSaveErrorTrip_r)
    else $error("no torn trip");
  chk_bad_trip: assert property (scan && memRsp.bankValid == 2'h0 |-> ##[1:3] memoryCorruptTrip_r)
    else $error("no corrupt trip");
  chk_fail_trip: assert property (err |-> ##[1:3] actionFailTrip_r)
    else $error("no fail trip");
endmodule
bind psbs_sequencer psbs_checker #(.SAVE_CYC(SAVE_CYC)) chk (.*);

// ==== psbs_mem_model.sv ====
/* Two-bank memory model. Assumes requests held until ack. */
`timescale 1ns/10ps
module psbs_mem_model
  import psbs_pkg::*;
(
  input wire logic sys_clk,
  input wire psbs_mem_req_t memReq,
  input wire logic failWr,
  input wire logic slow,
  input wire logic [1:0] scanValid,
  output psbs_mem_rsp_t memRsp,
  output logic act_r,
  output logic wrBank_r,
  output logic wrPds_r
);
  logic [1:0] wait_r = 2'h0;
  // Answer, report banks, switch on commit
  always_ff @(posedge sys_clk) begin
    memRsp <= '0;
    if (memReq.valid && !memRsp.ack) begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == {slow, slow}) begin
        wait_r <= 2'h0;
        memRsp <= '{1'h1, failWr && memReq.op == OP_WRITE, scanValid, scanValid == 2'h1, 1'h0, 1'h0};
        if (memReq.op == OP_SCAN) act_r <= 1'h0;
        if (memReq.op == OP_COMMIT) act_r <= memReq.bank;
        if (memReq.op == OP_WRITE) {wrBank_r, wrPds_r} <= {memReq.bank, memReq.inclPds};
      end
    end
  end
endmodule

// ==== testbench.sv ====
/* Bench of the sequencer. Assumes the memory model alongside. */
`timescale 1ns/10ps
module testbench
  import psbs_pkg::*;
;
  logic sys_clk = 1'h0, rst = 1'h1, wb_we_i = 1'h0, wb_stb_i = 1'h0, wb_cyc_i = 1'h0;
  logic unit400V = 1'h1, closedLoopMode = 1'h0, optionChangeToggle = 1'h0, failWr = 1'h0;
  logic undervoltageActiveFlag = 1'h0, lowVoltageSupplyFlag = 1'h0, slow = 1'h0;
  logic wb_ack_o, busy_r, userSaveErrorTrip_r, powerdownSaveErrorTrip_r, act, wrBank, wrPds;
  logic memoryCorruptTrip_r, actionFailTrip_r;
  logic [1:0] scanValid = 2'h3;
  logic [3:0] wb_sel_i = 4'hF;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  psbs_mem_req_t memReq_r;
  psbs_mem_rsp_t memRsp;
  psbs_disp_t displayMode_r;
  int n_fail = 0, checks = 0, cyc = 0;
  psbs_sequencer #(.SAVE_CYC(20)) dut (.*);
  psbs_mem_model mem (.sys_clk, .memReq(memReq_r), .failWr, .slow, .scanValid, .memRsp,
    .act_r(act), .wrBank_r(wrBank), .wrPds_r(wrPds));
  // Clock and hang limit
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 3000) begin n_fail++; complete_run(); end
  // Bus cycle, compare, wait for idle
  task automatic wb(logic [7:0] a, logic [31:0] d, logic w);
    {wb_adr_i, wb_dat_i, wb_we_i, wb_cyc_i, wb_stb_i} <= {a, d, w, 2'h3};
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge sys_clk);
  endtask
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin n_fail++; $display("mismatch %s exp %h saw %h", n, e, s); end
  endtask
  task idle;
    do @(posedge sys_clk); while (busy_r !== 1'h0);
  endtask
  task automatic job(logic [15:0] c, logic [7:0] t, logic [15:0] e);
    wb(ADDR_CMD, {16'h0, c}, 1'h1);
    wb(ADDR_CTRL, {24'h0, t}, 1'h1);
    idle();
    wb(ADDR_CMD, 32'h0, 1'h0);
    cmp("cmd", {16'h0, e}, rd);
  endtask
  task rstp;
    rst <= 1'h1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    idle();
  endtask
  // Scenarios
  task t_save;
    slow <= 1'h1;
    job(CODE_SAVE_ANY, 8'h01, 16'h0);
    cmp("bank", 32'h7, {act, wrBank, wrPds});
  endtask
  task t_refuse;
    wb(ADDR_CTRL, 32'h10, 1'h1);
    job(CODE_DEF_STD, 8'h11, CODE_DEF_STD);
    undervoltageActiveFlag <= 1'h1;
    job(CODE_SAVE_MAINS, 8'h01, CODE_SAVE_MAINS);
    job(CODE_SAVE_ANY, 8'h01, 16'h0);
    {undervoltageActiveFlag, lowVoltageSupplyFlag} <= 2'h1;
    job(CODE_SAVE_MAINS, 8'h01, CODE_SAVE_MAINS);
    lowVoltageSupplyFlag <= 1'h0;
    job(CODE_SAVE_MAINS, 8'h01, 16'h0);
  endtask
  task t_defaults;
    job(CODE_DEF_REG, 8'h01, 16'h0);
    cmp("pds", 32'h0, wrPds);
    cmp("clamp", REG_CLAMP_DHZ, memReq_r.clamp);
    cmp("volt", REG_RATED_V, memReq_r.ratedV);
    job(CODE_MODE_XREG, 8'h01, 16'h0);
    cmp("mpds", 32'h1, wrPds);
  endtask
  task t_fail;
    failWr <= 1'h1;
    job(CODE_SAVE_ANY, 8'h01, CODE_SAVE_ANY);
    failWr <= 1'h0;
    cmp("trip", 32'h1, actionFailTrip_r);
    wb(ADDR_CTRL, 32'h2, 1'h1);
    idle();
    cmp("quick", act, wrBank);
  endtask
  task t_disp;
    wb(ADDR_CMD, {16'h0, CODE_DISP_DESTINATION_CLASH_TRIP}, 1'h1);
    cmp("disp", DISP_DESTINATION_CLASH_TRIP, displayMode_r);
    wb(ADDR_CMD, {16'h0, CODE_DISP_NDEF}, 1'h1);
    cmp("ndef", DISP_NDEF, displayMode_r);
    wb(8'h0C, 32'h0, 1'h0);
    cmp("unmapped", 32'h0, rd);
  endtask
  task t_torn;
    scanValid <= 2'h1;
    rstp();
    cmp("torn", 32'h1, userSaveErrorTrip_r);
    scanValid <= 2'h0;
    rstp();
    cmp("corrupt", 32'h1, memoryCorruptTrip_r);
  endtask
  task complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rstp();
    t_save();
    t_refuse();
    t_defaults();
    t_fail();
    t_disp();
    t_torn();
    complete_run();
  end
endmodule
